//--- adccs_seq.sv
// Notes on behaviour
// - finished one-shot conversion pulses done and loads low/high result.
// - periodic mode converts one or two channels, named by the two slot fields.
// - each slot has its own 12-bit threshold and a comparison polarity.
// - periodic mode powers the converter up and down by itself.
// - every periodic conversion refreshes that slot's result pair.
// - queued periodic channels run in ascending order, lower into slot 0.
// - threshold crossing pulses an interrupt for one cycle after that result is stored.
// - a newer periodic result overwrites an unread or uncleared one.
// - periodic conversion never stalls on pending interrupts or unread data.
// - per slot, a crossing starts shutdown when its shutdown bit is set.
// - in off, only channels 0 to 4 are converted; sleep also allows the case below.
// - channels 5 and 6 also convert in sleep while thermal sensing is on.
// - channels 0, 1 and 3 have two stored deviations at codes 2064 and 3112.
// - a pending one-shot request goes before a pending periodic one.
// - results are unsigned 12-bit codes from 0 to 4095.
`timescale 1ns/1ns
`default_nettype none
module adccs_seq #(
    parameter int INTERVAL_BASE_CYCLES = adccs_pkg::INTERVAL_BASE_CYCLES,
    parameter int POWERUP_CYCLES       = adccs_pkg::POWERUP_CYCLES,
    parameter int TRIM_W               = adccs_pkg::TRIM_W
) (
    input  wire logic              sys_clk_in,
    input  wire logic              reset_in,
    input  wire logic [2:0]        oneshot_channel_in,
    input  wire logic              oneshot_request_select_in,
    input  wire logic [2:0]        slot0_channel_field_in,
    input  wire logic [2:0]        slot1_channel_field_in,
    input  wire logic              periodic_slot0_enable_in,
    input  wire logic              periodic_slot1_enable_in,
    input  wire logic [1:0]        periodic_interval_in,
    input  wire logic [1:0]        periodic_shutdown_enable_in,
    input  wire logic [1:0]        periodic_polarity_in,
    input  wire logic [7:0]        slot0_threshold_low_in,
    input  wire logic [3:0]        slot0_threshold_high_in,
    input  wire logic [7:0]        slot1_threshold_low_in,
    input  wire logic [3:0]        slot1_threshold_high_in,
    input  wire logic [1:0]        power_state_in,
    input  wire logic              thermal_sensor_enable_in,
    input  wire logic              high_supply_range_in,
    input  wire logic [TRIM_W-1:0] trim_deviation_1_in,
    input  wire logic [TRIM_W-1:0] trim_deviation_2_in,
    input  wire logic [TRIM_W-1:0] trim_deviation_3_in,
    input  wire logic [TRIM_W-1:0] trim_deviation_4_in,
    input  wire logic [TRIM_W-1:0] trim_deviation_5_in,
    input  wire logic [TRIM_W-1:0] trim_deviation_6_in,
    input  wire logic              conv_done_in,
    input  wire logic [11:0]       conv_code_in,
    output logic                   conv_power_out,
    output logic                   conv_start_out,
    output logic [2:0]             conv_channel_out,
    output logic                   oneshot_done_irq_out,
    output logic [7:0]             oneshot_result_low_out,
    output logic [3:0]             oneshot_result_high_out,
    output logic [7:0]             slot0_result_low_out,
    output logic [3:0]             slot0_result_high_out,
    output logic [7:0]             slot1_result_low_out,
    output logic [3:0]             slot1_result_high_out,
    output logic                   threshold_irq_out,
    output logic                   shutdown_request_out,
    output logic [TRIM_W-1:0]      cal_dev1_out,
    output logic [TRIM_W-1:0]      cal_dev2_out,
    output logic                   busy_out
);
    localparam int PU_W = $clog2(POWERUP_CYCLES + 1);

    // barred channels are dropped, not held, so a refused request can never stall the queue
    function automatic logic chan_allowed(input logic [2:0] ch, input logic [1:0] pst,
                                          input logic therm);
        logic ok;
        ok = 1'b1;
        if (pst != adccs_pkg::PWR_ACTIVE) begin
            ok = (ch <= adccs_pkg::CH_LOW_POWER_MAX);
            if ((pst == adccs_pkg::PWR_SLEEP) && therm &&
                ((ch == adccs_pkg::CH_TEMP0) || (ch == adccs_pkg::CH_TEMP1))) begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction : chan_allowed

    adccs_pkg::adccs_state_t state_r;
    logic [PU_W-1:0] pu_cnt_r;
    logic            os_pend_r;
    logic [2:0]      os_chan_r;
    logic [1:0]      per_pend_r;
    logic [2:0]      per_chan_r [2];
    logic            cur_os_r;
    logic            cur_slot_r;
    logic            tick;
    logic            per_run;
    logic            both_en;
    logic [2:0]      lo_ch;
    logic [2:0]      hi_ch;
    logic            take_os;
    logic            take_per;
    logic            per_idx;
    logic [2:0]      next_ch;
    logic            any_pend;
    logic            finish;
    logic [11:0]     os_res_r;
    logic [1:0]      crossed;

    adccs_slot_if sif [2] ();

    assign per_run  = periodic_slot0_enable_in || periodic_slot1_enable_in;
    assign both_en  = periodic_slot0_enable_in && periodic_slot1_enable_in;
    assign lo_ch    = (slot1_channel_field_in < slot0_channel_field_in) ?
                      slot1_channel_field_in : slot0_channel_field_in;
    assign hi_ch    = (slot1_channel_field_in < slot0_channel_field_in) ?
                      slot0_channel_field_in : slot1_channel_field_in;
    assign any_pend = os_pend_r || (per_pend_r != 2'b00);
    assign take_os  = os_pend_r;
    assign take_per = !os_pend_r && (per_pend_r != 2'b00);
    // slot 0 drains first, so after sorting the lower channel always lands there
    assign per_idx  = per_pend_r[0] ? 1'b0 : 1'b1;
    assign next_ch  = take_os ? os_chan_r : per_chan_r[per_idx];
    assign finish   = (state_r == adccs_pkg::ADCCS_WAIT) && conv_done_in;

    adccs_timer #(
        .BASE_CYCLES (INTERVAL_BASE_CYCLES)
    ) u_timer (
        .sys_clk_in  (sys_clk_in),
        .reset_in    (reset_in),
        .run_in      (per_run),
        .interval_in (periodic_interval_in),
        .tick_out    (tick)
    );

    // a request landing while the previous one is in its start or wait state is kept; one landing before its start state is lost
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            os_pend_r <= 1'b0;
            os_chan_r <= adccs_pkg::CH_EXT0;
        end else if (oneshot_request_select_in) begin
            os_pend_r <= 1'b1;
            os_chan_r <= oneshot_channel_in;
        end else if ((state_r == adccs_pkg::ADCCS_START) && cur_os_r) begin
            os_pend_r <= 1'b0;
        end
    end

    // a fresh tick re-queues the enabled slots even if the last round is unfinished
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            per_pend_r    <= 2'b00;
            per_chan_r[0] <= adccs_pkg::CH_EXT0;
            per_chan_r[1] <= adccs_pkg::CH_EXT0;
        end else if (tick) begin
            if (both_en) begin
                per_pend_r    <= 2'b11;
                per_chan_r[0] <= lo_ch;
                per_chan_r[1] <= hi_ch;
            end else begin
                per_pend_r    <= {periodic_slot1_enable_in, periodic_slot0_enable_in};
                per_chan_r[0] <= slot0_channel_field_in;
                per_chan_r[1] <= slot1_channel_field_in;
            end
        end else if ((state_r == adccs_pkg::ADCCS_START) && !cur_os_r) begin
            per_pend_r[cur_slot_r] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state_r          <= adccs_pkg::ADCCS_IDLE;
            pu_cnt_r         <= '0;
            cur_os_r         <= 1'b0;
            cur_slot_r       <= 1'b0;
            conv_power_out   <= 1'b0;
            conv_start_out   <= 1'b0;
            conv_channel_out <= adccs_pkg::CH_EXT0;
        end else begin
            conv_start_out <= 1'b0;
            case (state_r)
                adccs_pkg::ADCCS_IDLE: begin
                    if (take_os || take_per) begin
                        cur_os_r         <= take_os;
                        cur_slot_r       <= per_idx;
                        conv_channel_out <= next_ch;
                        conv_power_out   <= 1'b1;
                        pu_cnt_r         <= '0;
                        // power stays on between queued conversions, so only the first warms up
                        if (conv_power_out) begin
                            state_r <= adccs_pkg::ADCCS_START;
                        end else begin
                            state_r <= adccs_pkg::ADCCS_POWERUP;
                        end
                    end else begin
                        conv_power_out <= 1'b0;
                    end
                end
                adccs_pkg::ADCCS_POWERUP: begin
                    pu_cnt_r <= pu_cnt_r + PU_W'(1);
                    if (pu_cnt_r >= PU_W'(POWERUP_CYCLES - 1)) begin
                        state_r <= adccs_pkg::ADCCS_START;
                    end
                end
                adccs_pkg::ADCCS_START: begin
                    // channels barred in the present power state are dropped
                    if (chan_allowed(conv_channel_out, power_state_in,
                                     thermal_sensor_enable_in)) begin
                        conv_start_out <= 1'b1;
                        state_r        <= adccs_pkg::ADCCS_WAIT;
                    end else begin
                        state_r <= adccs_pkg::ADCCS_IDLE;
                    end
                end
                adccs_pkg::ADCCS_WAIT: begin
                    if (conv_done_in) begin
                        state_r <= adccs_pkg::ADCCS_IDLE;
                    end
                end
                default: begin
                    state_r <= adccs_pkg::ADCCS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            os_res_r             <= adccs_pkg::RST_CODE;
            oneshot_done_irq_out <= 1'b0;
        end else begin
            oneshot_done_irq_out <= finish && cur_os_r;
            if (finish && cur_os_r) begin
                os_res_r <= conv_code_in;
            end
        end
    end

    generate
        for (genvar s = 0; s < adccs_pkg::NUM_SLOTS; s++) begin : g_slot
            assign sif[s].wr   = finish && !cur_os_r && (cur_slot_r == 1'(s));
            assign sif[s].code = conv_code_in;
            assign sif[s].pol  = periodic_polarity_in[s];
            assign crossed[s]  = sif[s].crossed;
            adccs_slot u_slot (
                .sys_clk_in (sys_clk_in),
                .reset_in   (reset_in),
                .sif        (sif[s])
            );
        end
    endgenerate

    assign sif[0].thr = {slot0_threshold_high_in, slot0_threshold_low_in};
    assign sif[1].thr = {slot1_threshold_high_in, slot1_threshold_low_in};

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            threshold_irq_out    <= 1'b0;
            shutdown_request_out <= 1'b0;
        end else begin
            threshold_irq_out    <= |crossed;
            shutdown_request_out <= |(crossed & periodic_shutdown_enable_in);
        end
    end

    // the result outputs are flops already; the split is wiring only
    assign oneshot_result_low_out  = os_res_r[adccs_pkg::LOW_BYTE_MSB:0];
    assign oneshot_result_high_out = os_res_r[11:adccs_pkg::HIGH_NIB_LSB];
    assign slot0_result_low_out    = sif[0].res[adccs_pkg::LOW_BYTE_MSB:0];
    assign slot0_result_high_out   = sif[0].res[11:adccs_pkg::HIGH_NIB_LSB];
    assign slot1_result_low_out    = sif[1].res[adccs_pkg::LOW_BYTE_MSB:0];
    assign slot1_result_high_out   = sif[1].res[11:adccs_pkg::HIGH_NIB_LSB];

    // trim pair follows the selected one-shot channel; unsupported channels read zero
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            cal_dev1_out <= TRIM_W'(adccs_pkg::RST_TRIM);
            cal_dev2_out <= TRIM_W'(adccs_pkg::RST_TRIM);
        end else if ((oneshot_channel_in == adccs_pkg::CH_EXT0) ||
                     (oneshot_channel_in == adccs_pkg::CH_EXT1)) begin
            cal_dev1_out <= trim_deviation_1_in;
            cal_dev2_out <= trim_deviation_2_in;
        end else if (oneshot_channel_in == adccs_pkg::CH_SUPPLY) begin
            cal_dev1_out <= high_supply_range_in ? trim_deviation_5_in : trim_deviation_3_in;
            cal_dev2_out <= high_supply_range_in ? trim_deviation_6_in : trim_deviation_4_in;
        end else begin
            cal_dev1_out <= TRIM_W'(adccs_pkg::RST_TRIM);
            cal_dev2_out <= TRIM_W'(adccs_pkg::RST_TRIM);
        end
    end

    // busy covers the queue too, so queued but unstarted work is visible
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= any_pend || (state_r != adccs_pkg::ADCCS_IDLE);
        end
    end
endmodule : adccs_seq
`default_nettype wire

//--- adccs_pkg.sv
`default_nettype none
package adccs_pkg;

    localparam int          CODE_W          = 12;
    localparam int          CHAN_W          = 3;
    localparam int          TRIM_W          = 8;
    localparam int          NUM_SLOTS       = 2;

    localparam int          CLK_HZ          = 10_000_000;
    localparam int          INTERVAL_BASE_US = 10_000;
    localparam int          INTERVAL_BASE_CYCLES = (CLK_HZ / 1_000_000) * INTERVAL_BASE_US;
    localparam int          POWERUP_NS      = 2_000;
    localparam int          POWERUP_CYCLES  = (POWERUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    localparam logic [11:0] CODE_MIN        = 12'h000;
    localparam logic [11:0] CODE_MAX        = 12'hFFF;
    localparam int          LOW_BYTE_MSB    = 7;
    localparam int          HIGH_NIB_LSB    = 8;

    localparam logic [2:0]  CH_EXT0         = 3'h0;
    localparam logic [2:0]  CH_EXT1         = 3'h1;
    localparam logic [2:0]  CH_SUPPLY       = 3'h3;
    localparam logic [2:0]  CH_LOW_POWER_MAX = 3'h4;
    localparam logic [2:0]  CH_TEMP0        = 3'h5;
    localparam logic [2:0]  CH_TEMP1        = 3'h6;

    localparam int          CAL_X1          = 2064;
    localparam int          CAL_X2          = 3112;

    localparam logic [1:0]  PWR_ACTIVE      = 2'h0;
    localparam logic [1:0]  PWR_SLEEP       = 2'h1;
    localparam logic [1:0]  PWR_OFF         = 2'h2;

    localparam logic [1:0]  RST_SLOT_SEL    = 2'h0;
    localparam logic [11:0] RST_CODE        = 12'h000;
    localparam logic [7:0]  RST_TRIM        = 8'h00;

    typedef enum logic [1:0] {
        ADCCS_IDLE,
        ADCCS_POWERUP,
        ADCCS_START,
        ADCCS_WAIT
    } adccs_state_t;

endpackage : adccs_pkg
`default_nettype wire

//--- adccs_slot_if.sv
`timescale 1ns/1ns
`default_nettype none
interface adccs_slot_if;
    logic        wr;
    logic [11:0] code;
    logic [11:0] thr;
    logic        pol;
    logic        crossed;
    logic [11:0] res;

    modport ctrl (output wr, output code, output thr, output pol, input crossed, input res);
    modport slot (input wr, input code, input thr, input pol, output crossed, output res);
endinterface : adccs_slot_if
`default_nettype wire

//--- adccs_slot.sv
`timescale 1ns/1ns
`default_nettype none
module adccs_slot (
    input  wire logic    sys_clk_in,
    input  wire logic    reset_in,
    adccs_slot_if.slot   sif
);
    logic [11:0] res_r;
    logic        crossed_r;

    // the newest result always replaces the old one, read or not
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            res_r <= adccs_pkg::RST_CODE;
        end else if (sif.wr) begin
            res_r <= sif.code;
        end
    end

    // polarity high flags codes above the threshold, low flags codes below it
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            crossed_r <= 1'b0;
        end else begin
            crossed_r <= sif.wr && (sif.pol ? (sif.code > sif.thr) : (sif.code < sif.thr));
        end
    end

    assign sif.res     = res_r;
    assign sif.crossed = crossed_r;
endmodule : adccs_slot
`default_nettype wire

//--- adccs_timer.sv
`timescale 1ns/1ns
`default_nettype none
module adccs_timer #(
    parameter int BASE_CYCLES = adccs_pkg::INTERVAL_BASE_CYCLES
) (
    input  wire logic       sys_clk_in,
    input  wire logic       reset_in,
    input  wire logic       run_in,
    input  wire logic [1:0] interval_in,
    output logic            tick_out
);
    // interval code n gives a period of BASE_CYCLES times two to the n
    localparam int CNT_W = $clog2(BASE_CYCLES * 8 + 1);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] limit;

    assign limit = CNT_W'(BASE_CYCLES) << interval_in;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in || !run_in) begin
            cnt_r    <= '0;
            tick_out <= 1'b0;
        end else if (cnt_r >= limit - CNT_W'(1)) begin
            cnt_r    <= '0;
            tick_out <= 1'b1;
        end else begin
            cnt_r    <= cnt_r + CNT_W'(1);
            tick_out <= 1'b0;
        end
    end
endmodule : adccs_timer
`default_nettype wire

//--- adccs_seq_props.sv
`timescale 1ns/1ns
`default_nettype none
module adccs_seq_props #(
    parameter int POWERUP_CYCLES = adccs_pkg::POWERUP_CYCLES
) (
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    input  wire logic        oneshot_request_select_in,
    input  wire logic [1:0]  power_state_in,
    input  wire logic        thermal_sensor_enable_in,
    input  wire logic        conv_done_in,
    input  wire logic [11:0] conv_code_in,
    input  wire logic        conv_power_out,
    input  wire logic        conv_start_out,
    input  wire logic [2:0]  conv_channel_out,
    input  wire logic        oneshot_done_irq_out,
    input  wire logic [7:0]  oneshot_result_low_out,
    input  wire logic [3:0]  oneshot_result_high_out,
    input  wire logic [7:0]  slot0_result_low_out,
    input  wire logic [3:0]  slot0_result_high_out,
    input  wire logic [7:0]  slot1_result_low_out,
    input  wire logic [3:0]  slot1_result_high_out,
    input  wire logic        threshold_irq_out,
    input  wire logic        shutdown_request_out,
    input  wire logic        busy_out
);
    // request to start: two cycles of queueing, power-up, start state, margin
    localparam int REQ_MAX = POWERUP_CYCLES + 20;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    wire logic [11:0] os_res = {oneshot_result_high_out, oneshot_result_low_out};
    wire logic [23:0] sl_res = {slot1_result_high_out, slot1_result_low_out,
                                slot0_result_high_out, slot0_result_low_out};
    a_oneshot_done: assert property (
        oneshot_done_irq_out |-> $past(conv_done_in) && os_res == $past(conv_code_in))
        else $error("one-shot done without matching converter result");
    a_oneshot_hold: assert property (!$stable(os_res) |-> oneshot_done_irq_out)
        else $error("one-shot result changed without done pulse");
    a_slot_update: assert property (!$stable(sl_res) |-> $past(conv_done_in))
        else $error("slot result changed without a conversion");
    a_start_powered: assert property (
        conv_start_out |-> conv_power_out && $past(conv_power_out))
        else $error("start issued before converter powered");
    a_start_pulse: assert property (conv_start_out |=> !conv_start_out)
        else $error("start longer than one cycle");
    a_sleep_limit: assert property (
        conv_start_out && power_state_in != adccs_pkg::PWR_ACTIVE |->
        conv_channel_out <= adccs_pkg::CH_LOW_POWER_MAX ||
        (power_state_in == adccs_pkg::PWR_SLEEP && thermal_sensor_enable_in &&
         (conv_channel_out == adccs_pkg::CH_TEMP0 || conv_channel_out == adccs_pkg::CH_TEMP1)))
        else $error("channel converted in a low power state");
    a_irq_cause: assert property (threshold_irq_out |-> $past(conv_done_in, 2))
        else $error("threshold interrupt without a conversion");
    a_shutdown_irq: assert property (shutdown_request_out |-> threshold_irq_out)
        else $error("shutdown without threshold crossing");
    a_request_served: assert property (
        oneshot_request_select_in && !busy_out && power_state_in == adccs_pkg::PWR_ACTIVE
        |-> ##[1:REQ_MAX] conv_start_out)
        else $error("one-shot request not started in time");
    c_oneshot: cover property (oneshot_done_irq_out);
    c_shutdown: cover property (shutdown_request_out);
    c_sleep: cover property (conv_start_out && power_state_in == adccs_pkg::PWR_SLEEP);
endmodule : adccs_seq_props
bind adccs_seq adccs_seq_props #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_props (.*);
`default_nettype wire

//--- adccs_seq_tb.sv
`timescale 1ns/1ns
`default_nettype none
module adccs_seq_tb;
    logic        sys_clk_in = 1'b0, reset_in = 1'b1, req = 1'b0, en0 = 1'b0, en1 = 1'b0;
    logic        therm = 1'b0, hirange = 1'b0, conv_done_in = 1'b0;
    logic [2:0]  oneshot_channel_in = 3'h0, f0 = 3'h0, f1 = 3'h0, cch = 3'h0;
    logic [1:0]  interval = 2'h0, sd_en = 2'h0, pol = 2'h0, pstate = 2'h0;
    logic [11:0] thr0 = 12'h000, thr1 = 12'h000, conv_code_in = 12'h000, offs = 12'h05A;
    logic [7:0]  trim [1:6];
    logic        conv_power_out, conv_start_out, oneshot_done_irq_out, threshold_irq_out;
    logic        shutdown_request_out, busy_out;
    logic [2:0]  conv_channel_out;
    logic [7:0]  osl, s0l, s1l, dev1, dev2;
    logic [3:0]  osh, s0h, s1h;
    logic [3:0]  cdly = 4'h0;
    int          num_errors = 0, check_count = 0, irq_cnt = 0, sd_cnt = 0;

    adccs_seq #(.INTERVAL_BASE_CYCLES(20), .POWERUP_CYCLES(2)) uut (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .oneshot_channel_in(oneshot_channel_in),
        .oneshot_request_select_in(req), .slot0_channel_field_in(f0),
        .slot1_channel_field_in(f1), .periodic_slot0_enable_in(en0),
        .periodic_slot1_enable_in(en1), .periodic_interval_in(interval),
        .periodic_shutdown_enable_in(sd_en), .periodic_polarity_in(pol),
        .slot0_threshold_low_in(thr0[7:0]), .slot0_threshold_high_in(thr0[11:8]),
        .slot1_threshold_low_in(thr1[7:0]), .slot1_threshold_high_in(thr1[11:8]),
        .power_state_in(pstate), .thermal_sensor_enable_in(therm),
        .high_supply_range_in(hirange), .trim_deviation_1_in(trim[1]),
        .trim_deviation_2_in(trim[2]), .trim_deviation_3_in(trim[3]),
        .trim_deviation_4_in(trim[4]), .trim_deviation_5_in(trim[5]),
        .trim_deviation_6_in(trim[6]), .conv_done_in(conv_done_in),
        .conv_code_in(conv_code_in), .conv_power_out(conv_power_out),
        .conv_start_out(conv_start_out), .conv_channel_out(conv_channel_out),
        .oneshot_done_irq_out(oneshot_done_irq_out), .oneshot_result_low_out(osl),
        .oneshot_result_high_out(osh), .slot0_result_low_out(s0l), .slot0_result_high_out(s0h),
        .slot1_result_low_out(s1l), .slot1_result_high_out(s1h),
        .threshold_irq_out(threshold_irq_out), .shutdown_request_out(shutdown_request_out),
        .cal_dev1_out(dev1), .cal_dev2_out(dev2), .busy_out(busy_out));

    always #50 sys_clk_in = ~sys_clk_in;

    function automatic logic [11:0] code_of(input logic [2:0] ch);
        return {1'b0, ch, 8'h00} + offs;
    endfunction : code_of

    // converter stand-in: fixed latency, code bus scrambled outside the done cycle
    always @(posedge sys_clk_in) begin
        conv_done_in <= (cdly == 4'h1);
        conv_code_in <= (cdly == 4'h1) ? code_of(cch) : ~conv_code_in;
        if (conv_start_out === 1'b1) begin
            cdly <= 4'h3;
            cch <= conv_channel_out;
        end else if (cdly != 4'h0) begin
            cdly <= cdly - 4'h1;
        end
        if (threshold_irq_out === 1'b1) irq_cnt++;
        if (shutdown_request_out === 1'b1) sd_cnt++;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic oneshot(input logic [2:0] ch, input logic ok);
        int n;
        logic [11:0] prev;
        prev = {osh, osl};
        @(posedge sys_clk_in) oneshot_channel_in <= ch;
        @(posedge sys_clk_in) req <= 1'b1;
        @(posedge sys_clk_in) req <= 1'b0;
        n = 0;
        while (oneshot_done_irq_out !== 1'b1 && n < 60) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        check({15'h0, n < 60}, {15'h0, ok});
        check({4'h0, osh, osl}, {4'h0, ok ? code_of(ch) : prev});
    endtask : oneshot

    task automatic wait_slots(input logic [11:0] e0, input logic [11:0] e1);
        int n;
        n = 0;
        while (({s0h, s0l} !== e0 || {s1h, s1l} !== e1) && n < 300) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        check({4'h0, s0h, s0l}, {4'h0, e0});
        check({4'h0, s1h, s1l}, {4'h0, e1});
        repeat (3) @(posedge sys_clk_in);
        #1;
    endtask : wait_slots

    task automatic cal(input logic [2:0] ch, input logic rng, input logic [15:0] exp);
        @(posedge sys_clk_in) oneshot_channel_in <= ch;
        hirange <= rng;
        repeat (2) @(posedge sys_clk_in);
        #1;
        check({dev1, dev2}, exp);
    endtask : cal

    initial begin
        repeat (20000) @(posedge sys_clk_in);
        num_errors++;
        report_and_stop();
    end

    initial begin
        for (int i = 1; i <= 6; i++) trim[i] = 8'h11 * i[7:0];
        repeat (6) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        @(posedge sys_clk_in);
        #1;
        check({11'h0, conv_power_out, conv_start_out, busy_out, threshold_irq_out,
               shutdown_request_out}, 16'h0000);
        // first one-shot after reset converts channel 7, and its result is checked like the rest
        oneshot(3'h7, 1'b1);
        for (int c = 0; c < 7; c++) if (c != 2) oneshot(c[2:0], 1'b1);
        cal(3'h0, 1'b0, 16'h1122);
        cal(3'h1, 1'b1, 16'h1122);
        cal(3'h3, 1'b0, 16'h3344);
        cal(3'h3, 1'b1, 16'h5566);
        cal(3'h4, 1'b0, 16'h0000);
        // fields given in the wrong order on purpose: results still sort by channel
        @(posedge sys_clk_in) f0 <= 3'h4;
        f1 <= 3'h1;
        thr1 <= 12'hFFF;
        pol <= 2'b11;
        sd_en <= 2'b01;
        @(posedge sys_clk_in) en0 <= 1'b1;
        en1 <= 1'b1;
        wait_slots(code_of(3'h1), code_of(3'h4));
        check({15'h0, irq_cnt > 0}, 16'h0001);
        check({15'h0, sd_cnt > 0}, 16'h0001);
        @(posedge sys_clk_in) sd_en <= 2'b00;
        offs = 12'h0A5;
        irq_cnt = 0;
        sd_cnt = 0;
        // interrupt never cleared and results never read, yet rounds continue
        wait_slots(code_of(3'h1), code_of(3'h4));
        check({15'h0, irq_cnt > 0}, 16'h0001);
        check(sd_cnt[15:0], 16'h0000);
        @(posedge sys_clk_in) pol <= 2'b10;
        offs = 12'h0C3;
        irq_cnt = 0;
        wait_slots(code_of(3'h1), code_of(3'h4));
        check(irq_cnt[15:0], 16'h0000);
        oneshot(3'h0, 1'b1);
        @(posedge sys_clk_in) en0 <= 1'b0;
        f1 <= 3'h7;
        wait_slots(code_of(3'h1), code_of(3'h7));
        @(posedge sys_clk_in) en1 <= 1'b0;
        #1;
        for (int n = 0; n < 60 && conv_power_out !== 1'b0; n++) begin
            @(posedge sys_clk_in);
            #1;
        end
        check({15'h0, conv_power_out}, 16'h0000);
        @(posedge sys_clk_in) pstate <= adccs_pkg::PWR_SLEEP;
        oneshot(3'h5, 1'b0);
        oneshot(3'h4, 1'b1);
        @(posedge sys_clk_in) therm <= 1'b1;
        oneshot(3'h6, 1'b1);
        oneshot(3'h7, 1'b0);
        @(posedge sys_clk_in) pstate <= adccs_pkg::PWR_OFF;
        oneshot(3'h5, 1'b0);
        oneshot(3'h0, 1'b1);
        report_and_stop();
    end
endmodule : adccs_seq_tb
`default_nettype wire
